// file: hw/sbrg_pkg.sv
// constants of the serial rate generator: register map, field positions,
// reset values and divide ratios
// assumes an 8-bit register port and one system clock
package sbrg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] OFS_RX_CTRL = 8'h18;
  localparam logic [7:0] OFS_TX_CTRL = 8'h98;
  localparam logic [7:0] OFS_DIVISOR = 8'h99;
  localparam logic [7:0] OFS_STATUS = 8'h9a;
  // reset values
  localparam logic [7:0] RST_RX_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_CTRL = 8'h02;
  localparam logic [7:0] RST_DIVISOR = 8'h00;
  // writable bits
  localparam logic [7:0] WMASK_RX_CTRL = 8'hf8;
  localparam logic [7:0] WMASK_TX_CTRL = 8'hf5;
  // transmit_status_control fields
  localparam int TX_CLOCK_SOURCE_BIT = 7;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HIGH_SPEED_BIT = 2;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  // receive_status_control fields
  localparam int RX_SERIAL_ENABLE_BIT = 7;
  // status register fields
  localparam int ST_RX_BIT = 0;
  localparam int ST_RUNNING = 1;
  localparam int ST_SLEEP = 2;
  // divide ratios of the bit rate against the system clock
  localparam int PRESCALE = 4;
  localparam int DIV_SYNC = 4;
  localparam int DIV_ASYNC_HIGH = 16;
  localparam int DIV_ASYNC_LOW = 64;
  localparam int PRE_W = 2;
  localparam int PHASE_W = 4;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
  localparam logic [PHASE_W-1:0] PHASES_SYNC = PHASE_W'(DIV_SYNC / PRESCALE - 1);
  localparam logic [PHASE_W-1:0] PHASES_HIGH = PHASE_W'(DIV_ASYNC_HIGH / PRESCALE - 1);
  localparam logic [PHASE_W-1:0] PHASES_LOW = PHASE_W'(DIV_ASYNC_LOW / PRESCALE - 1);
  // samples taken per received bit
  localparam int SAMPLES = 3;
endpackage

// file: hw/sbrg_smp_if.sv
// carries the sample strobes and majority result between the generator
// and its majority sampler; one clock domain
`timescale 1ns/10ps
`default_nettype none
interface sbrg_smp_if;
  logic sample_en;
  logic clear;
  logic pin_level;
  logic level;
  logic full;
  modport prod (output sample_en, output clear, output pin_level, input level, input full);
  modport cons (input sample_en, input clear, input pin_level, output level, output full);
endinterface
`default_nettype wire

// file: hw/sbrg_majority.sv
// three-sample majority detector for the receive pin
// assumes the pin level is already synchronised to the clock
`timescale 1ns/10ps
`default_nettype none
module sbrg_majority (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // strobes and result
  sbrg_smp_if.cons smp
);
  logic [sbrg_pkg::SAMPLES-1:0] shift_q, shift_d;
  logic [1:0] cnt_q, cnt_d;

  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    if (smp.clear) begin
      cnt_d = 2'h0;
    end
    if (smp.sample_en) begin
      shift_d = {shift_q[sbrg_pkg::SAMPLES-2:0], smp.pin_level};
      if (cnt_d != 2'(sbrg_pkg::SAMPLES)) begin
        cnt_d = cnt_d + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= 3'h7;
      cnt_q <= 2'h0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
    end
  end

  assign smp.level = (shift_q[0] & shift_q[1]) | (shift_q[1] & shift_q[2])
                     | (shift_q[0] & shift_q[2]);
  assign smp.full = (cnt_q == 2'(sbrg_pkg::SAMPLES));
endmodule
`default_nettype wire

// file: hw/sbrg_top.sv
// serial bit-rate generator with its control registers and receive sampler
// assumes a same-clock register port; pins arrive asynchronously
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module sbrg_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [sbrg_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sbrg_pkg::DATA_W-1:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [sbrg_pkg::DATA_W-1:0] RD_DATA,
  // power and neighbour status
  input wire logic SLEEP,
  input wire logic TX_SHIFT_EMPTY,
  // pins
  input wire logic RX_PIN,
  input wire logic CK_PIN,
  // rate and receive outputs
  output logic BAUD_TICK,
  output logic RX_BIT,
  output logic RX_BIT_STROBE,
  // mode outputs
  output logic SYNC_MODE,
  output logic HIGH_SPEED,
  output logic MASTER_MODE,
  output logic SERIAL_ENABLE
);
  // control registers
  logic [7:0] rx_ctrl_q, rx_ctrl_d;
  logic [7:0] tx_ctrl_q, tx_ctrl_d;
  logic [7:0] divisor_q, divisor_d;
  logic [7:0] rd_data_q, rd_data_d;
  // synchronisers
  logic rx_s1_q, rx_s2_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  // generator state
  logic [sbrg_pkg::PRE_W-1:0] pre_q, pre_d;
  logic [7:0] timer_q, timer_d;
  logic [sbrg_pkg::PHASE_W-1:0] phase_q, phase_d;
  logic tick_q, tick_d;
  logic rx_bit_q, rx_bit_d;
  logic strobe_q, strobe_d;
  // decoded controls
  logic div_write;
  logic run;
  logic gen_clear;
  logic pre_tick;
  logic rate_tick;
  logic bit_end;
  logic slave_edge;
  logic [sbrg_pkg::PHASE_W-1:0] phase_last;
  logic [sbrg_pkg::PHASE_W-1:0] phase_mid;
  logic sync_m, high_m, master_m, enable_m;
  logic [7:0] status;
  // registered copies of the mode bits for the outputs
  logic sync_q, sync_d, high_q, high_d;
  logic master_q, master_d, enable_q, enable_d;
  // synchroniser next values
  logic rx_s1_d, rx_s2_d;
  logic ck_s1_d, ck_s2_d, ck_s3_d;

  // true on the three rate ticks centred on the middle of a bit
  function automatic logic in_window(input logic [sbrg_pkg::PHASE_W-1:0] phase,
                                     input logic [sbrg_pkg::PHASE_W-1:0] mid);
    logic [sbrg_pkg::PHASE_W-1:0] lo;
    logic [sbrg_pkg::PHASE_W-1:0] hi;
    lo = mid - sbrg_pkg::PHASE_W'(1);
    hi = mid + sbrg_pkg::PHASE_W'(1);
    return (phase >= lo) && (phase <= hi);
  endfunction

  sbrg_smp_if smp ();

  sbrg_majority u_majority (
    .clk(CLOCK),
    .rst(RST),
    .smp(smp)
  );

  // register write path
  always_comb begin
    rx_ctrl_d = rx_ctrl_q;
    tx_ctrl_d = tx_ctrl_q;
    divisor_d = divisor_q;
    if (WR_STB) begin
      unique case (ADDR)
        sbrg_pkg::OFS_RX_CTRL: begin
          rx_ctrl_d = WR_DATA & sbrg_pkg::WMASK_RX_CTRL;
        end
        sbrg_pkg::OFS_TX_CTRL: begin
          tx_ctrl_d = WR_DATA & sbrg_pkg::WMASK_TX_CTRL;
        end
        sbrg_pkg::OFS_DIVISOR: begin
          divisor_d = WR_DATA;
        end
        default: begin
        end
      endcase
    end
  end

  assign div_write = WR_STB && (ADDR == sbrg_pkg::OFS_DIVISOR);

  // live status of the generator
  always_comb begin
    status = 8'h00;
    status[sbrg_pkg::ST_RX_BIT] = rx_bit_q;
    status[sbrg_pkg::ST_RUNNING] = run;
    status[sbrg_pkg::ST_SLEEP] = SLEEP;
  end

  // read data stand one cycle after the strobe
  always_comb begin
    rd_data_d = 8'h00;
    if (RD_STB) begin
      unique case (ADDR)
        sbrg_pkg::OFS_RX_CTRL: begin
          rd_data_d = rx_ctrl_q;
        end
        sbrg_pkg::OFS_TX_CTRL: begin
          rd_data_d = tx_ctrl_q;
          rd_data_d[sbrg_pkg::TX_SHIFT_EMPTY_BIT] = TX_SHIFT_EMPTY;
        end
        sbrg_pkg::OFS_DIVISOR: begin
          rd_data_d = divisor_q;
        end
        sbrg_pkg::OFS_STATUS: begin
          rd_data_d = status;
        end
        default: begin
          rd_data_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_ctrl_q <= sbrg_pkg::RST_RX_CTRL;
      tx_ctrl_q <= sbrg_pkg::RST_TX_CTRL;
      divisor_q <= sbrg_pkg::RST_DIVISOR;
      rd_data_q <= 8'h00;
    end else begin
      rx_ctrl_q <= rx_ctrl_d;
      tx_ctrl_q <= tx_ctrl_d;
      divisor_q <= divisor_d;
      rd_data_q <= rd_data_d;
    end
  end

  // pin synchronisers; ck_s3 only follows ck_s2 for edge finding
  always_comb begin
    rx_s1_d = RX_PIN;
    rx_s2_d = rx_s1_q;
    ck_s1_d = CK_PIN;
    ck_s2_d = ck_s1_q;
    ck_s3_d = ck_s2_q;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_s1_q <= 1'h1;
      rx_s2_q <= 1'h1;
      ck_s1_q <= 1'h0;
      ck_s2_q <= 1'h0;
      ck_s3_q <= 1'h0;
    end else begin
      rx_s1_q <= rx_s1_d;
      rx_s2_q <= rx_s2_d;
      ck_s1_q <= ck_s1_d;
      ck_s2_q <= ck_s2_d;
      ck_s3_q <= ck_s3_d;
    end
  end

  assign sync_m = tx_ctrl_q[sbrg_pkg::TX_SYNC_BIT];
  assign master_m = tx_ctrl_q[sbrg_pkg::TX_CLOCK_SOURCE_BIT];
  assign enable_m = rx_ctrl_q[sbrg_pkg::RX_SERIAL_ENABLE_BIT];
  assign high_m = tx_ctrl_q[sbrg_pkg::TX_HIGH_SPEED_BIT] & ~sync_m;

  // mode outputs take the next register values, so they move with the registers
  always_comb begin
    sync_d = tx_ctrl_d[sbrg_pkg::TX_SYNC_BIT];
    master_d = tx_ctrl_d[sbrg_pkg::TX_CLOCK_SOURCE_BIT];
    enable_d = rx_ctrl_d[sbrg_pkg::RX_SERIAL_ENABLE_BIT];
    high_d = tx_ctrl_d[sbrg_pkg::TX_HIGH_SPEED_BIT] & ~sync_d;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sync_q <= sbrg_pkg::RST_TX_CTRL[sbrg_pkg::TX_SYNC_BIT];
      master_q <= sbrg_pkg::RST_TX_CTRL[sbrg_pkg::TX_CLOCK_SOURCE_BIT];
      enable_q <= sbrg_pkg::RST_RX_CTRL[sbrg_pkg::RX_SERIAL_ENABLE_BIT];
      high_q <= sbrg_pkg::RST_TX_CTRL[sbrg_pkg::TX_HIGH_SPEED_BIT]
                & ~sbrg_pkg::RST_TX_CTRL[sbrg_pkg::TX_SYNC_BIT];
    end else begin
      sync_q <= sync_d;
      master_q <= master_d;
      enable_q <= enable_d;
      high_q <= high_d;
    end
  end

  assign run = enable_m & ~SLEEP;
  assign gen_clear = div_write | ~run;

  assign pre_tick = run && (pre_q == sbrg_pkg::PRE_LAST);
  assign rate_tick = pre_tick && (timer_q == 8'h00);

  always_comb begin
    if (sync_m) begin
      phase_last = sbrg_pkg::PHASES_SYNC;
    end else if (high_m) begin
      phase_last = sbrg_pkg::PHASES_HIGH;
    end else begin
      phase_last = sbrg_pkg::PHASES_LOW;
    end
  end

  assign phase_mid = phase_last >> 1;
  assign bit_end = rate_tick && (phase_q == phase_last);

  assign slave_edge = run && ck_s2_q && !ck_s3_q;

  always_comb begin
    pre_d = pre_q;
    timer_d = timer_q;
    phase_d = phase_q;
    if (gen_clear) begin
      pre_d = '0;
      timer_d = divisor_d;
      phase_d = '0;
    end else begin
      pre_d = pre_q + sbrg_pkg::PRE_W'(1);
      if (pre_tick) begin
        if (timer_q == 8'h00) begin
          timer_d = divisor_q;
        end else begin
          timer_d = timer_q - 8'h01;
        end
      end
      if (rate_tick) begin
        if (phase_q == phase_last) begin
          phase_d = '0;
        end else begin
          phase_d = phase_q + sbrg_pkg::PHASE_W'(1);
        end
      end
    end
  end

  // bit tick and received bit
  always_comb begin
    tick_d = 1'h0;
    rx_bit_d = rx_bit_q;
    strobe_d = 1'h0;
    if (sync_m && !master_m) begin
      tick_d = slave_edge;
    end else begin
      // a tick due in a clearing cycle is dropped so the new period starts whole
      tick_d = bit_end && !gen_clear;
    end
    if (tick_d && smp.full) begin
      rx_bit_d = smp.level;
      strobe_d = 1'h1;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pre_q <= '0;
      timer_q <= sbrg_pkg::RST_DIVISOR;
      phase_q <= '0;
      tick_q <= 1'h0;
      rx_bit_q <= 1'h1;
      strobe_q <= 1'h0;
    end else begin
      pre_q <= pre_d;
      timer_q <= timer_d;
      phase_q <= phase_d;
      tick_q <= tick_d;
      rx_bit_q <= rx_bit_d;
      strobe_q <= strobe_d;
    end
  end

  always_comb begin
    smp.pin_level = rx_s2_q;
    // every tick or clear starts a fresh set of three samples
    smp.clear = tick_d | gen_clear;
    if (sync_m) begin
      smp.sample_en = run;
    end else begin
      smp.sample_en = rate_tick && in_window(phase_q, phase_mid);
    end
  end

  // outputs: data from flip-flops, modes from their registered copies
  assign RD_DATA = rd_data_q;
  assign BAUD_TICK = tick_q;
  assign RX_BIT = rx_bit_q;
  assign RX_BIT_STROBE = strobe_q;
  assign SYNC_MODE = sync_q;
  assign HIGH_SPEED = high_q;
  assign MASTER_MODE = master_q;
  assign SERIAL_ENABLE = enable_q;
endmodule
`default_nettype wire

// file: tb/sbrg_top_sva.sv
// checker of tick timing, divisor readback and receive sampler outputs
// assumes it is bound to sbrg_top and sees one clock
`timescale 1ns/10ps
`default_nettype none
module sbrg_top_sva (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port and power
  input wire logic [sbrg_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sbrg_pkg::DATA_W-1:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [sbrg_pkg::DATA_W-1:0] RD_DATA,
  input wire logic SLEEP,
  // watched outputs
  input wire logic BAUD_TICK,
  input wire logic RX_BIT,
  input wire logic RX_BIT_STROBE,
  input wire logic SYNC_MODE,
  input wire logic HIGH_SPEED,
  input wire logic MASTER_MODE,
  input wire logic SERIAL_ENABLE
);
  logic [7:0] div_q, div_d;
  logic [15:0] cnt_q, cnt_d, per;
  logic valid_q, valid_d, first_q, first_d, hold;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // cycles since the last tick or write; a tick right at a write is ignored
  always_comb begin
    hold = SLEEP || !SERIAL_ENABLE || (SYNC_MODE && !MASTER_MODE);
    per = (SYNC_MODE ? 16'h4 : HIGH_SPEED ? 16'h10 : 16'h40) * (16'(div_q) + 16'h1);
    div_d = div_q;
    cnt_d = cnt_q + 16'h1;
    valid_d = valid_q;
    first_d = first_q;
    if (BAUD_TICK && cnt_q != 16'h0) begin
      cnt_d = 16'h1;
      valid_d = 1'b1;
      first_d = 1'b0;
    end
    if (WR_STB) begin
      cnt_d = 16'h0;
      valid_d = 1'b0;
      first_d = (ADDR == sbrg_pkg::OFS_DIVISOR);
    end
    if (WR_STB && ADDR == sbrg_pkg::OFS_DIVISOR) begin
      div_d = WR_DATA;
    end
    if (hold) begin
      valid_d = 1'b0;
      first_d = 1'b0;
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_q <= sbrg_pkg::RST_DIVISOR;
      cnt_q <= 16'h0;
      valid_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      valid_q <= valid_d;
      first_q <= first_d;
    end
  end
  sequence s_asleep;
    SLEEP [*2];
  endsequence
  sequence s_div_read;
    RD_STB && ADDR == sbrg_pkg::OFS_DIVISOR;
  endsequence
  chk_tick_pulse: assert property (BAUD_TICK |=> !BAUD_TICK)
    else $error("tick longer than one cycle");
  chk_tick_period: assert property (BAUD_TICK && valid_q |-> cnt_q == per)
    else $error("tick period wrong");
  chk_first_tick: assert property (BAUD_TICK && first_q && cnt_q != 16'h0 |-> cnt_q == per)
    else $error("first tick after divisor write misplaced");
  chk_sleep_quiet: assert property (s_asleep |-> !BAUD_TICK)
    else $error("tick while asleep");
  chk_div_read: assert property (s_div_read |=> RD_DATA == div_q)
    else $error("divisor readback wrong");
  chk_sync_hs: assert property (SYNC_MODE |-> !HIGH_SPEED)
    else $error("high speed seen in synchronous mode");
  chk_strobe_tick: assert property (RX_BIT_STROBE |-> BAUD_TICK)
    else $error("sample strobe without tick");
  chk_rx_hold: assert property (!RX_BIT_STROBE |-> $stable(RX_BIT))
    else $error("received level changed without strobe");
endmodule
bind sbrg_top sbrg_top_sva chk (.CLOCK, .RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA,
  .SLEEP, .BAUD_TICK, .RX_BIT, .RX_BIT_STROBE, .SYNC_MODE, .HIGH_SPEED, .MASTER_MODE,
  .SERIAL_ENABLE);
`default_nettype wire

// file: tb/sbrg_remote.sv
// remote serial device: drives the receive line and, as clock master, the serial clock
// assumes the bench clock; the serial clock idles low outside transfers
`timescale 1ns/10ps
`default_nettype none
module sbrg_remote #(parameter int HALF = 4) (
  // clock
  input wire logic clk,
  // controls from the bench
  input wire logic ck_run,
  input wire logic line_level,
  // pins
  output logic rx_pin,
  output logic ck_pin
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!ck_run) begin
      cnt_q <= 8'h0;
      ck_pin <= 1'b0;
    end else if (cnt_q == 8'(HALF - 1)) begin
      cnt_q <= 8'h0;
      ck_pin <= !ck_pin;
    end else begin
      cnt_q <= cnt_q + 8'h1;
    end
  end
  assign rx_pin = line_level;
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench of the serial rate generator
// assumes sbrg_top, its checker bound in, and the remote model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] tx; logic [7:0] dv; logic [15:0] per;} sbrg_row_t;
  logic CLOCK = 1'b0, RST = 1'b1, WR_STB = 1'b0, RD_STB = 1'b0, SLEEP = 1'b0;
  logic TX_SHIFT_EMPTY = 1'b1, ck_run = 1'b0, line_level = 1'b1;
  logic [7:0] ADDR = 8'h00, WR_DATA = 8'h00, d;
  wire logic RX_PIN, CK_PIN, BAUD_TICK, RX_BIT, RX_BIT_STROBE;
  wire logic SYNC_MODE, HIGH_SPEED, MASTER_MODE, SERIAL_ENABLE;
  wire logic [7:0] RD_DATA;
  int n_errors = 0, checks_done = 0, cycles = 0, n;
  // high-speed division chosen for some rates
  // transmit control, divisor, expected period in clocks
  sbrg_row_t rows [6] = '{'{8'h90, 8'h00, 16'h0004}, '{8'h94, 8'h02, 16'h000c},
    '{8'h04, 8'h00, 16'h0010}, '{8'h00, 8'h01, 16'h0080}, '{8'h04, 8'hff, 16'h1000},
    '{8'h90, 8'hff, 16'h0400}};
  sbrg_top dut (.CLOCK, .RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA, .SLEEP,
    .TX_SHIFT_EMPTY, .RX_PIN, .CK_PIN, .BAUD_TICK, .RX_BIT, .RX_BIT_STROBE, .SYNC_MODE,
    .HIGH_SPEED, .MASTER_MODE, .SERIAL_ENABLE);
  sbrg_remote peer (.clk(CLOCK), .ck_run, .line_level, .rx_pin(RX_PIN), .ck_pin(CK_PIN));
  always #25 CLOCK = !CLOCK;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    WR_DATA <= v;
    WR_STB <= 1'b1;
    @(posedge CLOCK);
    WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLOCK);
    RD_STB <= 1'b0;
    #1 v = RD_DATA;
  endtask
  // cycles from the present edge to the next tick
  task automatic measure(output int k);
    k = 0;
    do begin
      @(posedge CLOCK);
      #1 k++;
    end while (BAUD_TICK !== 1'b1 && k < 20000);
  endtask
  task automatic count_ticks(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(posedge CLOCK);
      #1 if (BAUD_TICK === 1'b1) k++;
    end
  endtask
  task automatic wait_strobes;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge CLOCK);
        #1 n++;
      end while (RX_BIT_STROBE !== 1'b1 && n < 200);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    rd(sbrg_pkg::OFS_RX_CTRL, d);
    check(16'(d), 16'h0000);
    rd(sbrg_pkg::OFS_TX_CTRL, d);
    check(16'(d), 16'h0002);
    rd(sbrg_pkg::OFS_DIVISOR, d);
    check(16'(d), 16'h0000);
    rd(8'h55, d);
    check(16'(d), 16'h0000);
    wr(sbrg_pkg::OFS_TX_CTRL, 8'hff);
    rd(sbrg_pkg::OFS_TX_CTRL, d);
    check(16'(d), 16'h00f7);
    check(16'(HIGH_SPEED), 16'h0000);
    wr(sbrg_pkg::OFS_RX_CTRL, 8'h80);
    foreach (rows[i]) begin
      wr(sbrg_pkg::OFS_TX_CTRL, rows[i].tx);
      wr(sbrg_pkg::OFS_DIVISOR, rows[i].dv);
      measure(n);
      check(16'(n), rows[i].per);
      measure(n);
      check(16'(n), rows[i].per);
      check(16'({MASTER_MODE, SYNC_MODE}), 16'({rows[i].tx[7], rows[i].tx[4]}));
      check(16'(SERIAL_ENABLE), 16'h0001);
      check(16'(HIGH_SPEED), 16'(rows[i].tx[2] & ~rows[i].tx[4]));
      rd(sbrg_pkg::OFS_DIVISOR, d);
      check(16'(d), 16'(rows[i].dv));
    end
    // rewrite in mid-period of the slowest synchronous rate
    repeat (100) @(posedge CLOCK);
    wr(sbrg_pkg::OFS_DIVISOR, 8'h00);
    measure(n);
    check(16'(n), 16'h0004);
    @(posedge CLOCK);
    SLEEP <= 1'b1;
    count_ticks(40, n);
    check(16'(n), 16'h0000);
    rd(sbrg_pkg::OFS_STATUS, d);
    check(16'(d), 16'h0005);
    @(posedge CLOCK);
    SLEEP <= 1'b0;
    measure(n);
    measure(n);
    check(16'(n), 16'h0004);
    rd(sbrg_pkg::OFS_STATUS, d);
    check(16'(d), 16'h0003);
    wr(sbrg_pkg::OFS_TX_CTRL, 8'h04);
    line_level <= 1'b0;
    wait_strobes();
    check(16'(RX_BIT), 16'h0000);
    @(posedge CLOCK);
    line_level <= 1'b1;
    wait_strobes();
    check(16'(RX_BIT), 16'h0001);
    wr(sbrg_pkg::OFS_TX_CTRL, 8'h10);
    ck_run <= 1'b1;
    count_ticks(160, n);
    check(16'(n >= 19 && n <= 20), 16'h0001);
    ck_run <= 1'b0;
    repeat (10) @(posedge CLOCK);
    count_ticks(40, n);
    check(16'(n), 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
